// ---- include/adsq_params.svh ----
// Register offsets, field positions and reset values of the converter sequencer.
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define ADSQ_ADDR_W        5
`define ADSQ_DATA_W        16
`define ADSQ_RES_W         12
`define ADSQ_WORDS         16
`define ADSQ_CHAN_W        4

// ----------------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------------
`define ADSQ_OFF_CTRL1     5'h00
`define ADSQ_OFF_CTRL2     5'h01
`define ADSQ_OFF_CHSEL     5'h02
`define ADSQ_OFF_SCAN      5'h03
`define ADSQ_OFF_ISTAT     5'h04
`define ADSQ_OFF_IMASK     5'h05
`define ADSQ_RES_BASE_BIT  4

// ----------------------------------------------------------------------------
// Field positions of the first control register
// ----------------------------------------------------------------------------
`define ADSQ_C1_DONE       0
`define ADSQ_C1_SAMPLE_START_BIT       1
`define ADSQ_C1_CONV       2
`define ADSQ_C1_TRIG_LO    5
`define ADSQ_C1_TRIG_HI    6
`define ADSQ_C1_FORM_LO    8
`define ADSQ_C1_FORM_HI    9
`define ADSQ_C1_ON         15

// ----------------------------------------------------------------------------
// Field positions of the second control register
// ----------------------------------------------------------------------------
`define ADSQ_C2_ALTERNATE_INPUT_SELECT       0
`define ADSQ_C2_BUFFER_SPLIT_MODE       1
`define ADSQ_C2_SAMPLES_PER_IRQ_LO    2
`define ADSQ_C2_SAMPLES_PER_IRQ_HI    5
`define ADSQ_C2_HALF       7
`define ADSQ_C2_SCAN       10

// ----------------------------------------------------------------------------
// Field positions of the input select register and interrupt bits
// ----------------------------------------------------------------------------
`define ADSQ_CH_PRI_LO     0
`define ADSQ_CH_PRI_HI     3
`define ADSQ_CH_SEC_LO     8
`define ADSQ_CH_SEC_HI     11
`define ADSQ_IRQ_DONE      0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ADSQ_RST_SAMPLES_PER_IRQ      4'h0
`define ADSQ_RST_MASK      16'h0000
`define ADSQ_RST_CHAN      4'h0

`endif

// ---- include/adsq_pkg.sv ----
// Types shared by the converter sequencer modules.
`include "adsq_params.svh"

package adsq_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {
    ADSQ_IDLE    = 2'b00,
    ADSQ_SAMPLE  = 2'b01,
    ADSQ_CONVERT = 2'b10
  } adsq_seq_t;

  // Trigger sources that end acquisition.
  typedef enum logic [1:0] {
    ADSQ_TRIG_MANUAL = 2'b00,
    ADSQ_TRIG_TIMER  = 2'b01,
    ADSQ_TRIG_EXT    = 2'b10,
    ADSQ_TRIG_NONE   = 2'b11
  } adsq_trig_t;

  // Register bus request from software.
  typedef struct packed {
    logic [`ADSQ_ADDR_W-1:0] addr;
    logic [`ADSQ_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } adsq_bus_req_t;

  // Result coming back from the analog converter.
  typedef struct packed {
    logic                   done;
    logic [`ADSQ_RES_W-1:0] data;
  } adsq_conv_in_t;

  // Control going to the analog converter.
  typedef struct packed {
    logic                    sample_en;
    logic                    start;
    logic [`ADSQ_CHAN_W-1:0] chan;
  } adsq_conv_out_t;

  // Whole state of the sequencer.
  typedef struct packed {
    adsq_seq_t                                 seq;
    logic                                      adc_on;
    logic                                      sample_start_bit;
    logic                                      done;
    adsq_trig_t                                trig_src;
    logic [1:0]                                form;
    logic                                      scan_inputs_enable;
    logic [3:0]                                samples_per_irq;
    logic                                      buffer_split_mode;
    logic                                      alternate_input_select;
    logic [`ADSQ_CHAN_W-1:0]                   pri_chan;
    logic [`ADSQ_CHAN_W-1:0]                   sec_chan;
    logic [`ADSQ_WORDS-1:0]                    scan_select_mask;
    logic                                      converter_irq_flag;
    logic                                      irq_mask;
    logic [3:0]                                count;
    logic                                      half;
    logic                                      alt_phase;
    logic [4:0]                                scan_pos;
    logic                                      cur_grp_a;
    logic                                      ext_prev;
    logic [`ADSQ_WORDS-1:0][`ADSQ_RES_W-1:0]   result_buf;
    logic [`ADSQ_DATA_W-1:0]                   rdata;
    adsq_conv_out_t                            conv_out;
    logic                                      irq;
  } adsq_state_t;

endpackage

// ---- hdl/adsq_sync.sv ----
// Two-stage synchroniser for inputs that arrive from outside the clock domain.
`timescale 1ns/1ps

module adsq_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] sync_reg;
  logic [1:0][W-1:0] sync_next;

  // The first stage feeds only the second stage.
  always_comb begin
    sync_next = {sync_reg[0], d};
  end

  // Both stages clear on reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg[1];

endmodule // adsq_sync

// ---- hdl/adsq_top.sv ----
// Sequencer and result buffer of a 12-bit analog-to-digital converter.
`timescale 1ns/1ps
`include "adsq_params.svh"

module adsq_top (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire adsq_pkg::adsq_bus_req_t bus_req,
  output logic [`ADSQ_DATA_W-1:0]      bus_rdata,
  input  wire adsq_pkg::adsq_conv_in_t conv_in,
  input  wire logic                    timer_tick,
  input  wire logic                    ext_trig,
  output adsq_pkg::adsq_conv_out_t     conv_out,
  output logic                         irq
);

  // --------------------------------------------------------------------------
  // State and helper signals
  // --------------------------------------------------------------------------
  adsq_pkg::adsq_state_t   st_reg;
  adsq_pkg::adsq_state_t   st_next;
  logic                    ext_sync;
  logic                    ext_rise;
  logic                    manual_trig;
  logic                    trig;
  logic                    store;
  logic                    irq_event;
  logic                    use_grp_a;
  logic [`ADSQ_CHAN_W-1:0] scan_chan;
  logic [`ADSQ_CHAN_W-1:0] sel_chan;
  logic [3:0]              wr_idx;

  // External trigger pin passes two flip-flops before use.
  adsq_sync #(
    .W (1)
  ) u_ext_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       (ext_trig),
    .q       (ext_sync)
  );

  // --------------------------------------------------------------------------
  // Result formatting
  // --------------------------------------------------------------------------

  // Maps a stored 12-bit result onto one of four 16-bit formats.
  function automatic logic [`ADSQ_DATA_W-1:0] fmt_result(
    input logic [1:0]             form,
    input logic [`ADSQ_RES_W-1:0] d
  );
    logic [`ADSQ_DATA_W-1:0] v;
    unique case (form)
      2'b00: v = {4'h0, d};
      2'b01: v = {{4{~d[11]}}, ~d[11], d[10:0]};
      2'b10: v = {d, 4'h0};
      2'b11: v = {~d[11], d[10:0], 4'h0};
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Input selection
  // --------------------------------------------------------------------------

  // Picks the lowest masked input at or above the scan position, else wraps low.
  always_comb begin
    logic                    hit;
    logic [`ADSQ_CHAN_W-1:0] above;
    logic [`ADSQ_CHAN_W-1:0] lowest;
    hit    = 1'b0;
    above  = `ADSQ_RST_CHAN;
    lowest = `ADSQ_RST_CHAN;
    for (int i = `ADSQ_WORDS - 1; i >= 0; i--) begin
      if (st_reg.scan_select_mask[i]) begin
        lowest = 4'(i);
        if (5'(i) >= st_reg.scan_pos) begin
          hit   = 1'b1;
          above = 4'(i);
        end
      end
    end
    scan_chan = hit ? above : lowest;
  end

  // Chooses the group and input for the next sequence.
  always_comb begin
    use_grp_a = ~st_reg.alternate_input_select | ~st_reg.alt_phase;
    if (!use_grp_a) begin
      sel_chan = st_reg.sec_chan;
    end else if (st_reg.scan_inputs_enable) begin
      sel_chan = scan_chan;
    end else begin
      sel_chan = st_reg.pri_chan;
    end
  end

  // --------------------------------------------------------------------------
  // Events
  // --------------------------------------------------------------------------

  // Trigger, store and interrupt conditions of this cycle.
  always_comb begin
    ext_rise    = ext_sync & ~st_reg.ext_prev;
    manual_trig = bus_req.wr && (bus_req.addr == `ADSQ_OFF_CTRL1)
                  && bus_req.wdata[`ADSQ_C1_CONV];
    unique case (st_reg.trig_src)
      adsq_pkg::ADSQ_TRIG_MANUAL: trig = manual_trig;
      adsq_pkg::ADSQ_TRIG_TIMER:  trig = timer_tick;
      adsq_pkg::ADSQ_TRIG_EXT:    trig = ext_rise;
      adsq_pkg::ADSQ_TRIG_NONE:   trig = 1'b0;
    endcase
    store     = st_reg.adc_on && (st_reg.seq == adsq_pkg::ADSQ_CONVERT) && conv_in.done;
    irq_event = store && (st_reg.count >= st_reg.samples_per_irq);
    // Split mode keeps the index inside the active half.
    wr_idx    = st_reg.buffer_split_mode ? {st_reg.half, st_reg.count[2:0]}
                                         : st_reg.count;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------

  // Register writes first, then hardware events so that a hardware event beats a write in the same cycle.
  always_comb begin
    st_next                = st_reg;
    st_next.conv_out.start = 1'b0;
    st_next.rdata          = '0;
    st_next.ext_prev       = ext_sync;

    // Software writes; result words ignore them.
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ADSQ_OFF_CTRL1: begin
          st_next.adc_on           = bus_req.wdata[`ADSQ_C1_ON];
          st_next.trig_src         = adsq_pkg::adsq_trig_t'(
                                     bus_req.wdata[`ADSQ_C1_TRIG_HI:`ADSQ_C1_TRIG_LO]);
          st_next.form             = bus_req.wdata[`ADSQ_C1_FORM_HI:`ADSQ_C1_FORM_LO];
          st_next.sample_start_bit = bus_req.wdata[`ADSQ_C1_SAMPLE_START_BIT];
          if (bus_req.wdata[`ADSQ_C1_SAMPLE_START_BIT]) begin
            st_next.done = 1'b0;
          end
        end
        `ADSQ_OFF_CTRL2: begin
          st_next.scan_inputs_enable     = bus_req.wdata[`ADSQ_C2_SCAN];
          st_next.samples_per_irq        =
            bus_req.wdata[`ADSQ_C2_SAMPLES_PER_IRQ_HI:`ADSQ_C2_SAMPLES_PER_IRQ_LO];
          st_next.buffer_split_mode      = bus_req.wdata[`ADSQ_C2_BUFFER_SPLIT_MODE];
          st_next.alternate_input_select = bus_req.wdata[`ADSQ_C2_ALTERNATE_INPUT_SELECT];
        end
        `ADSQ_OFF_CHSEL: begin
          st_next.pri_chan = bus_req.wdata[`ADSQ_CH_PRI_HI:`ADSQ_CH_PRI_LO];
          st_next.sec_chan = bus_req.wdata[`ADSQ_CH_SEC_HI:`ADSQ_CH_SEC_LO];
        end
        `ADSQ_OFF_SCAN:  st_next.scan_select_mask = bus_req.wdata;
        `ADSQ_OFF_ISTAT: begin
          if (bus_req.wdata[`ADSQ_IRQ_DONE]) begin
            st_next.converter_irq_flag = 1'b0;
          end
        end
        `ADSQ_OFF_IMASK: st_next.irq_mask = bus_req.wdata[`ADSQ_IRQ_DONE];
        default: ;
      endcase
    end

    // Read data for the cycle after the strobe.
    if (bus_req.rd) begin
      if (bus_req.addr[`ADSQ_RES_BASE_BIT]) begin
        st_next.rdata = fmt_result(st_reg.form, st_reg.result_buf[bus_req.addr[3:0]]);
      end else begin
        unique case (bus_req.addr)
          `ADSQ_OFF_CTRL1: begin
            st_next.rdata[`ADSQ_C1_ON]                        = st_reg.adc_on;
            st_next.rdata[`ADSQ_C1_TRIG_HI:`ADSQ_C1_TRIG_LO] = st_reg.trig_src;
            st_next.rdata[`ADSQ_C1_FORM_HI:`ADSQ_C1_FORM_LO] = st_reg.form;
            st_next.rdata[`ADSQ_C1_SAMPLE_START_BIT]                      = st_reg.sample_start_bit;
            st_next.rdata[`ADSQ_C1_DONE]                      = st_reg.done;
          end
          `ADSQ_OFF_CTRL2: begin
            st_next.rdata[`ADSQ_C2_SCAN]                      = st_reg.scan_inputs_enable;
            st_next.rdata[`ADSQ_C2_HALF]                      = st_reg.half;
            st_next.rdata[`ADSQ_C2_SAMPLES_PER_IRQ_HI:`ADSQ_C2_SAMPLES_PER_IRQ_LO] = st_reg.samples_per_irq;
            st_next.rdata[`ADSQ_C2_BUFFER_SPLIT_MODE]                      = st_reg.buffer_split_mode;
            st_next.rdata[`ADSQ_C2_ALTERNATE_INPUT_SELECT]                      = st_reg.alternate_input_select;
          end
          `ADSQ_OFF_CHSEL: begin
            st_next.rdata[`ADSQ_CH_PRI_HI:`ADSQ_CH_PRI_LO] = st_reg.pri_chan;
            st_next.rdata[`ADSQ_CH_SEC_HI:`ADSQ_CH_SEC_LO] = st_reg.sec_chan;
          end
          `ADSQ_OFF_SCAN:  st_next.rdata = st_reg.scan_select_mask;
          `ADSQ_OFF_ISTAT: st_next.rdata[`ADSQ_IRQ_DONE] = st_reg.converter_irq_flag;
          `ADSQ_OFF_IMASK: st_next.rdata[`ADSQ_IRQ_DONE] = st_reg.irq_mask;
          default:         st_next.rdata = '0;
        endcase
      end
    end

    // Sequencer; switching the converter off aborts any sequence.
    unique case (st_reg.seq)
      adsq_pkg::ADSQ_IDLE: begin
        if (st_reg.adc_on && st_reg.sample_start_bit) begin
          st_next.seq                = adsq_pkg::ADSQ_SAMPLE;
          st_next.conv_out.sample_en = 1'b1;
          st_next.conv_out.chan      = sel_chan;
          st_next.cur_grp_a          = use_grp_a;
        end
      end
      adsq_pkg::ADSQ_SAMPLE: begin
        if (!st_reg.adc_on) begin
          st_next.seq                = adsq_pkg::ADSQ_IDLE;
          st_next.conv_out.sample_en = 1'b0;
        end else if (trig) begin
          st_next.seq                = adsq_pkg::ADSQ_CONVERT;
          st_next.conv_out.sample_en = 1'b0;
          st_next.conv_out.start     = 1'b1;
          st_next.sample_start_bit   = 1'b0;
        end
      end
      adsq_pkg::ADSQ_CONVERT: begin
        if (!st_reg.adc_on || store) begin
          st_next.seq = adsq_pkg::ADSQ_IDLE;
        end
      end
      default: st_next.seq = adsq_pkg::ADSQ_IDLE;
    endcase

    // Storing a result advances pointer, scan position and group phase.
    if (store) begin
      st_next.result_buf[wr_idx] = conv_in.data;
      st_next.count              = st_reg.count + 4'h1;
      if (st_reg.alternate_input_select) begin
        st_next.alt_phase = ~st_reg.alt_phase;
      end
      if (st_reg.cur_grp_a && st_reg.scan_inputs_enable) begin
        st_next.scan_pos = {1'b0, st_reg.conv_out.chan} + 5'h01;
      end
      if (irq_event) begin
        st_next.count              = 4'h0;
        st_next.done               = 1'b1;
        st_next.converter_irq_flag = 1'b1;
        st_next.scan_pos           = 5'h00;
        st_next.half               = st_reg.buffer_split_mode & ~st_reg.half;
      end
    end

    // Level interrupt from unmasked sticky status.
    st_next.irq = st_next.converter_irq_flag & st_next.irq_mask;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Every field takes a constant on reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg                 <= '0;
      st_reg.seq             <= adsq_pkg::ADSQ_IDLE;
      st_reg.samples_per_irq <= `ADSQ_RST_SAMPLES_PER_IRQ;
      st_reg.count           <= 4'h0;
      st_reg.scan_pos        <= 5'h00;
      st_reg.scan_select_mask <= `ADSQ_RST_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign conv_out  = st_reg.conv_out;
  assign irq       = st_reg.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // A start request seen in idle.
  sequence s_start;
    st_reg.seq == adsq_pkg::ADSQ_IDLE && st_reg.adc_on && st_reg.sample_start_bit;
  endsequence

  // A trigger seen during acquisition.
  sequence s_trigger;
    st_reg.seq == adsq_pkg::ADSQ_SAMPLE && st_reg.adc_on && trig;
  endsequence

  a_result_hold: assert property (!store |=> $stable(st_reg.result_buf))
    else $error("Result buffer changed without a stored conversion.");

  a_sample_start: assert property (s_start |=> st_reg.seq == adsq_pkg::ADSQ_SAMPLE
                                   && conv_out.sample_en)
    else $error("Sampling did not begin after a start request.");

  a_trig_convert: assert property (s_trigger |=> conv_out.start && !conv_out.sample_en
                                   ##1 !conv_out.start)
    else $error("Trigger did not give a one-cycle conversion start.");

  a_done_count: assert property (irq_event |=> st_reg.done && st_reg.converter_irq_flag
                                 && st_reg.count == 4'h0 ##1 irq == st_reg.irq_mask)
    else $error("Done or flag missing after the programmed count.");

  a_count_step: assert property (store && !irq_event
                                 |=> st_reg.count == $past(st_reg.count) + 4'h1)
    else $error("Sample count did not advance by one.");

  a_half_swap: assert property (irq_event && st_reg.buffer_split_mode
                                |=> st_reg.half != $past(st_reg.half))
    else $error("Buffer half did not swap at the interrupt.");

  a_whole_buf: assert property (irq_event && !st_reg.buffer_split_mode
                                |=> st_reg.half == 1'b0)
    else $error("Half select set while split mode is off.");

  a_primary_only: assert property ((s_start and (!st_reg.alternate_input_select
                                   && !st_reg.scan_inputs_enable))
                                   |=> conv_out.chan == $past(st_reg.pri_chan))
    else $error("Primary group not used with alternate select off.");

  a_alt_swap: assert property ((s_start and (st_reg.alternate_input_select
                               && st_reg.alt_phase))
                               |=> conv_out.chan == $past(st_reg.sec_chan))
    else $error("Secondary group not used on the alternate sequence.");

  a_scan_restart: assert property (irq_event |=> st_reg.scan_pos == 5'h00)
    else $error("Scan did not restart after the interrupt.");

  a_done_clear: assert property (bus_req.wr && bus_req.addr == `ADSQ_OFF_CTRL1
                                 && bus_req.wdata[`ADSQ_C1_SAMPLE_START_BIT] && !irq_event
                                 |=> !st_reg.done)
    else $error("Done flag not cleared by a new start.");

endmodule // adsq_top

// ---- verification/tb_top.sv ----
// Self-checking testbench of the converter sequencer.
`timescale 1ns/1ps
`include "adsq_params.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic                     sys_clk = 1'b0;
  logic                     nrst = 1'b0;
  adsq_pkg::adsq_bus_req_t  bus_req = '0;
  adsq_pkg::adsq_conv_in_t  conv_in = '0;
  logic                     timer_tick = 1'b0;
  logic                     ext_trig = 1'b0;
  logic [15:0]              bus_rdata;
  adsq_pkg::adsq_conv_out_t conv_out;
  logic                     irq;
  logic                     rd_seen = 1'b0;
  logic [15:0]              rq[$];
  logic [3:0]               cq[$];
  logic [15:0]              rexp;
  logic [3:0]               cexp;
  logic [11:0]              d0, d1;
  int                       failures = 0;
  int                       checks_done = 0;

  always #20 sys_clk = ~sys_clk;

  adsq_top dut (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .conv_in(conv_in), .timer_tick(timer_tick), .ext_trig(ext_trig), .conv_out(conv_out),
    .irq(irq));

  // The monitor takes the oldest note whenever read data or a conversion start appears.
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      rexp = rq.pop_front();
      `CHK("bus_rdata", rexp, bus_rdata)
    end
    if (conv_out.start === 1'b1) begin
      cexp = cq.pop_front();
      `CHK("chan", cexp, conv_out.chan)
    end
    rd_seen <= bus_req.rd;
  end

  // -------------------------------------------------------------------------
  // Bus and sequence tasks
  // -------------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    bus(a, 16'h0000, 1'b0);
  endtask

  // Waits at falling edges, so settled values are seen, for acquisition or a start pulse.
  task automatic wait_for(input logic s);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 60) begin
        failures++;
        $display("MISMATCH wait expected 1 seen 0");
        end_of_test();
      end
    end while ((s ? conv_out.start : conv_out.sample_en) !== 1'b1);
  endtask

  // One sequence; the trigger is 0 manual, 1 timer or 2 external.
  task automatic seq(input logic [1:0] t, input logic [3:0] ch, input logic [11:0] d);
    cq.push_back(ch);
    bus(`ADSQ_OFF_CTRL1, 16'h8002 | (16'(t) << 5), 1'b1);
    wait_for(1'b0);
    if (t == 2'h0) bus(`ADSQ_OFF_CTRL1, 16'h8004, 1'b1);
    else begin
      @(posedge sys_clk);
      timer_tick <= (t == 2'h1);
      ext_trig <= (t == 2'h2);
      @(posedge sys_clk);
      timer_tick <= 1'b0;
      ext_trig <= 1'b0;
    end
    wait_for(1'b1);
    @(posedge sys_clk);
    conv_in <= '{done: 1'b1, data: d};
    @(posedge sys_clk);
    conv_in.done <= 1'b0;
    // Keeps at least 125 clocks (5 us) between samples, so at most 200 ksps.
    repeat (125) @(posedge sys_clk);
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] f, input logic [11:0] d);
    case (f)
      2'h0: return {4'h0, d};
      2'h1: return {{5{~d[11]}}, d[10:0]};
      2'h2: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h04521715));
    d0 = 12'($urandom);
    d1 = 12'($urandom);
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`ADSQ_OFF_CTRL2, 16'h0000);
    bus(5'h10, 16'hffff, 1'b1);
    rd(5'h10, 16'h0000);
    $display("test reset_and_readonly done");
    bus(`ADSQ_OFF_CTRL2, 16'h0004, 1'b1);
    bus(`ADSQ_OFF_CHSEL, 16'h0903, 1'b1);
    bus(`ADSQ_OFF_IMASK, 16'h0001, 1'b1);
    seq(2'h0, 4'h3, d0);
    rd(`ADSQ_OFF_ISTAT, 16'h0000);
    seq(2'h1, 4'h3, d1);
    rd(`ADSQ_OFF_ISTAT, 16'h0001);
    rd(`ADSQ_OFF_CTRL1, 16'h8021);
    @(negedge sys_clk);
    `CHK("irq", 1'b1, irq)
    for (int f = 0; f < 4; f++) begin
      bus(`ADSQ_OFF_CTRL1, 16'h8000 | (16'(f) << 8), 1'b1);
      rd(5'h10, fmt(f[1:0], d0));
      rd(5'h11, fmt(f[1:0], d1));
    end
    bus(`ADSQ_OFF_IMASK, 16'h0000, 1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK("irq", 1'b0, irq)
    bus(`ADSQ_OFF_ISTAT, 16'h0001, 1'b1);
    rd(`ADSQ_OFF_ISTAT, 16'h0000);
    $display("test count_format_irq done");
    bus(`ADSQ_OFF_CTRL2, 16'h0001, 1'b1);
    seq(2'h0, 4'h3, d0);
    seq(2'h2, 4'h9, d1);
    $display("test alternate done");
    bus(`ADSQ_OFF_CTRL2, 16'h0408, 1'b1);
    bus(`ADSQ_OFF_SCAN, 16'h1124, 1'b1);
    seq(2'h2, 4'h2, d0);
    seq(2'h1, 4'h5, d0);
    seq(2'h0, 4'h8, d1);
    seq(2'h2, 4'h2, d1);
    rd(5'h12, {4'h0, d1});
    // Completes the interrupt group so the sample count is zero for the split test.
    seq(2'h1, 4'h5, d0);
    seq(2'h0, 4'h8, d0);
    $display("test scan done");
    bus(`ADSQ_OFF_CTRL2, 16'h001e, 1'b1);
    for (int i = 0; i < 8; i++) seq(2'h0, 4'h3, 12'(i));
    rd(`ADSQ_OFF_CTRL2, 16'h009e);
    seq(2'h0, 4'h3, d0);
    rd(5'h17, 16'h0007);
    rd(5'h18, {4'h0, d0});
    $display("test split done");
    end_of_test();
  end
endmodule // tb_top
